/* hw/aia_bank.sv */
// Register bank of the eight-channel analog input module
//
// Operation
// [R1] High flag is 1 while the channel's value exceeds its high threshold.
// [R2] Low flag is 1 while the channel's value is below its low threshold.
// [R3] Read-only signed 16-bit maximum kept per channel.
// [R4] Read-only signed 16-bit minimum kept per channel.
// [R5] Channel count register reads eight.
// [R6] Peer link state reads zero when healthy, negative when failed.
// [R7] Station number is writable 0 to 255, factory value 1.
// [R8] High thresholds are signed, writable, factory value 32767.
// [R9] Low thresholds are signed, writable, factory value -32768.
// [R10] Reset cause reads 1 power-on, 2 watchdog, 3 software.
// [R11] Boot counter spans 1 to 32767; factory restore clears it.
// [R12] Model code register returns a fixed 16-bit identifier.
// [R13] Alarm mode 0 is momentary, 1 latches until cleared.
// [R14] Host clears a channel's maximum by writing 1 to its coil.
// [R15] Flags and extremes refresh on each new sample.
// [R16] Extremes change only on strictly greater or smaller samples; the code also takes any sample that arrives with a clear.
`timescale 1ns/100ps
`include "aia_consts.svh"
module aia_bank #(
    parameter logic [15:0] MODEL_CODE = 16'h5A5A,
    parameter logic [15:0] FW_REVISION = 16'h0100
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire aia_pkg::aia_req_t req,
    input wire aia_pkg::aia_sample_t sample,
    input wire logic link_ok_pin,
    input wire logic [1:0] cause_pin,
    input wire logic [14:0] boot_count_pin,
    output aia_pkg::aia_resp_t resp,
    output logic reboot_req,
    output logic factory_req,
    output logic [7:0] high_alarm_flags,
    output logic [7:0] low_alarm_flags
);
    import aia_pkg::*;

    localparam int NCH = 8;

    logic [15:0] high_thr [NCH];
    logic [15:0] low_thr [NCH];
    logic [15:0] range_code [NCH];
    logic [15:0] value [NCH];
    logic [15:0] hist_max [NCH];
    logic [15:0] hist_min [NCH];
    logic [7:0] high_mode;
    logic [7:0] low_mode;
    logic [7:0] high_now;
    logic [7:0] low_now;
    logic [15:0] station_number;
    logic [1:0] reset_cause;
    logic [14:0] startup_counter;
    logic captured;
    logic link_meta, link_sync;
    logic [1:0] cause_meta, cause_sync;
    logic [14:0] boot_meta, boot_sync;
    logic wr, rd, coil_wr, hold_wr, one;
    logic [7:0] clr_max, clr_min, clr_high, clr_low;
    logic factory;
    logic [15:0] next_rdata;
    logic next_err;

    // Hit test of an eight-word block, returns the channel in low bits
    function automatic logic [3:0] blk(input logic [15:0] a,
                                       input logic [15:0] base);
        logic [15:0] d;
        d = a - base;
        blk = (d < 16'h0008) ? {1'b1, d[2:0]} : 4'h0;
    endfunction

    function automatic logic [7:0] coil_hit(input logic [15:0] a,
                                            input logic [15:0] base,
                                            input logic en);
        logic [3:0] h;
        h = blk(a, base);
        coil_hit = (en && h[3]) ? (8'h01 << h[2:0]) : 8'h00;
    endfunction

    assign wr = req.valid & req.write;
    assign rd = req.valid & ~req.write;
    assign coil_wr = wr & (req.space == AIA_SP_COIL);
    assign hold_wr = wr & (req.space == AIA_SP_HOLDING);
    assign one = req.wdata[0];
    // [R14] Per-channel clear coils
    assign clr_max = coil_hit(req.addr, `AIA_COIL_CLR_MAX, coil_wr & one);
    assign clr_min = coil_hit(req.addr, `AIA_COIL_CLR_MIN, coil_wr & one);
    assign clr_high = coil_hit(req.addr, `AIA_COIL_CLR_HIGH, coil_wr & one);
    assign clr_low = coil_hit(req.addr, `AIA_COIL_CLR_LOW, coil_wr & one);
    assign factory = coil_wr & one & (req.addr == `AIA_COIL_FACTORY);

    // Pin synchronisers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_meta <= 1'b0;
            link_sync <= 1'b0;
            cause_meta <= 2'h0;
            cause_sync <= 2'h0;
            boot_meta <= 15'h0000;
            boot_sync <= 15'h0000;
        end else begin
            link_meta <= link_ok_pin;
            link_sync <= link_meta;
            cause_meta <= cause_pin;
            cause_sync <= cause_meta;
            boot_meta <= boot_count_pin;
            boot_sync <= boot_meta;
        end
    end

    // Start-up capture once the synchronisers hold valid pin levels
    logic [1:0] settle;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            settle <= 2'h0;
            captured <= 1'b0;
        end else begin
            if (settle != 2'h3) begin
                settle <= settle + 2'h1;
            end
            captured <= captured | (settle == 2'h3);
        end
    end

    // [R10] Cause caught after release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reset_cause <= `AIA_CAUSE_POWER_ON;
        end else if (!captured && settle == 2'h3) begin
            reset_cause <= (cause_sync == 2'h0) ? `AIA_CAUSE_POWER_ON
                                                 : cause_sync;
        end
    end

    // [R11] Boot counter, cleared by factory restore
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            startup_counter <= 15'h0000;
        end else if (factory) begin
            startup_counter <= 15'h0000;
        end else if (!captured && settle == 2'h3) begin
            startup_counter <= (boot_sync == `AIA_STARTUP_MAX) ?
                               `AIA_STARTUP_MAX : boot_sync + 15'h0001;
        end
    end

    // [R7] Station number write
    always_ff @(posedge clk) begin
        if (sys_rst || factory) begin
            station_number <= `AIA_RST_STATION;
        end else if (hold_wr && req.addr == `AIA_OFF_STATION &&
                     req.wdata <= `AIA_MAX_STATION) begin
            station_number <= req.wdata;
        end
    end

    // [R13] Alarm mode coils
    always_ff @(posedge clk) begin
        if (sys_rst || factory) begin
            high_mode <= 8'h00;
            low_mode <= 8'h00;
        end else begin
            high_mode <= high_mode & ~coil_hit(req.addr, `AIA_COIL_HIGH_MODE,
                         coil_wr) | coil_hit(req.addr, `AIA_COIL_HIGH_MODE,
                         coil_wr & one);
            low_mode <= low_mode & ~coil_hit(req.addr, `AIA_COIL_LOW_MODE,
                        coil_wr) | coil_hit(req.addr, `AIA_COIL_LOW_MODE,
                        coil_wr & one);
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            logic [3:0] hh, hl, hr;
            assign hh = blk(req.addr, `AIA_OFF_HIGH_THR);
            assign hl = blk(req.addr, `AIA_OFF_LOW_THR);
            assign hr = blk(req.addr, `AIA_OFF_RANGE);

            // [R8] [R9] Threshold and range storage
            always_ff @(posedge clk) begin
                if (sys_rst || factory) begin
                    high_thr[g] <= `AIA_RST_HIGH_THR;
                    low_thr[g] <= `AIA_RST_LOW_THR;
                    range_code[g] <= `AIA_RST_RANGE;
                end else if (hold_wr) begin
                    if (hh[3] && hh[2:0] == 3'(g)) begin
                        high_thr[g] <= req.wdata;
                    end
                    if (hl[3] && hl[2:0] == 3'(g)) begin
                        low_thr[g] <= req.wdata;
                    end
                    if (hr[3] && hr[2:0] == 3'(g)) begin
                        range_code[g] <= req.wdata;
                    end
                end
            end

            // [R15] Sample steering
            aia_chan u_chan (
                .clk(clk),
                .sys_rst(sys_rst),
                .sample_en(sample.valid && sample.ch == 3'(g)),
                .sample_value(sample.value),
                .high_thr(high_thr[g]),
                .low_thr(low_thr[g]),
                .high_latch(high_mode[g]),
                .low_latch(low_mode[g]),
                .clr_high(clr_high[g]),
                .clr_low(clr_low[g]),
                .clr_max(clr_max[g]),
                .clr_min(clr_min[g]),
                .value(value[g]),
                .hist_max(hist_max[g]),
                .hist_min(hist_min[g]),
                .high_flag(high_now[g]),
                .low_flag(low_now[g])
            );
        end
    endgenerate

    // Read decode per space
    always_comb begin
        logic [3:0] h;
        h = 4'h0;
        next_rdata = 16'h0000;
        next_err = 1'b0;
        case (req.space)
            AIA_SP_DISCRETE: begin
                h = blk(req.addr, `AIA_OFF_HIGH_FLAGS);
                if (h[3]) begin
                    next_rdata = {15'h0000, high_now[h[2:0]]};
                end else begin
                    h = blk(req.addr, `AIA_OFF_LOW_FLAGS);
                    next_rdata = {15'h0000, low_now[h[2:0]]};
                    next_err = ~h[3] | req.write;
                end
                next_err = next_err | req.write;
            end
            AIA_SP_INPUT: begin
                next_err = req.write;
                if (blk(req.addr, `AIA_OFF_INPUT_VALUE) != 4'h0) begin
                    h = blk(req.addr, `AIA_OFF_INPUT_VALUE);
                    next_rdata = value[h[2:0]];
                end else if (blk(req.addr, `AIA_OFF_HISTORY_MAX) != 4'h0) begin
                    h = blk(req.addr, `AIA_OFF_HISTORY_MAX);
                    next_rdata = hist_max[h[2:0]];
                end else if (blk(req.addr, `AIA_OFF_HISTORY_MIN) != 4'h0) begin
                    h = blk(req.addr, `AIA_OFF_HISTORY_MIN);
                    next_rdata = hist_min[h[2:0]];
                // [R5] Fixed channel count
                end else if (req.addr == `AIA_OFF_CH_COUNT) begin
                    next_rdata = {12'h000, `AIA_NUM_CH};
                end else if (req.addr == `AIA_OFF_FIRMWARE) begin
                    next_rdata = FW_REVISION;
                // [R6] Link state value
                end else if (req.addr == `AIA_OFF_PEER_LINK) begin
                    next_rdata = link_sync ? `AIA_LINK_NORMAL
                                           : `AIA_LINK_FAILED;
                end else begin
                    next_err = 1'b1;
                end
            end
            AIA_SP_HOLDING: begin
                if (req.addr == `AIA_OFF_STATION) begin
                    next_rdata = station_number;
                    next_err = req.write && req.wdata > `AIA_MAX_STATION;
                end else if (blk(req.addr, `AIA_OFF_HIGH_THR) != 4'h0) begin
                    h = blk(req.addr, `AIA_OFF_HIGH_THR);
                    next_rdata = high_thr[h[2:0]];
                end else if (blk(req.addr, `AIA_OFF_LOW_THR) != 4'h0) begin
                    h = blk(req.addr, `AIA_OFF_LOW_THR);
                    next_rdata = low_thr[h[2:0]];
                end else if (blk(req.addr, `AIA_OFF_RANGE) != 4'h0) begin
                    h = blk(req.addr, `AIA_OFF_RANGE);
                    next_rdata = range_code[h[2:0]];
                end else if (req.addr == `AIA_OFF_RESET_CAUSE) begin
                    next_rdata = {14'h0000, reset_cause};
                    next_err = req.write;
                end else if (req.addr == `AIA_OFF_STARTUPS) begin
                    next_rdata = {1'b0, startup_counter};
                    next_err = req.write;
                // [R12] Fixed model code
                end else if (req.addr == `AIA_OFF_MODEL) begin
                    next_rdata = MODEL_CODE;
                    next_err = req.write;
                end else begin
                    next_err = 1'b1;
                end
            end
            AIA_SP_COIL: begin
                next_err = ~req.write;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resp <= '0;
        end else begin
            resp.ack <= req.valid;
            resp.err <= req.valid & next_err;
            resp.rdata <= rd ? next_rdata : 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reboot_req <= 1'b0;
            factory_req <= 1'b0;
            high_alarm_flags <= 8'h00;
            low_alarm_flags <= 8'h00;
        end else begin
            reboot_req <= coil_wr & one & (req.addr == `AIA_COIL_REBOOT);
            factory_req <= factory;
            high_alarm_flags <= high_now;
            low_alarm_flags <= low_now;
        end
    end
endmodule // aia_bank

/* hw/aia_consts.svh */
// Offsets, reset values and fixed codes of the analog input register bank
`ifndef AIA_CONSTS_SVH
`define AIA_CONSTS_SVH

`define AIA_NUM_CH 4'h8
`define AIA_OFF_INPUT_VALUE 16'h0000
`define AIA_OFF_HIGH_FLAGS 16'h00E0
`define AIA_OFF_HISTORY_MAX 16'h00EC
`define AIA_OFF_LOW_FLAGS 16'h0100
`define AIA_OFF_HISTORY_MIN 16'h010C
`define AIA_OFF_STATION 16'h010F
`define AIA_OFF_HIGH_THR 16'h0128
`define AIA_OFF_CH_COUNT 16'h0140
`define AIA_OFF_LOW_THR 16'h0148
`define AIA_OFF_FIRMWARE 16'h015F
`define AIA_OFF_PEER_LINK 16'h0168
`define AIA_OFF_RANGE 16'h01AB
`define AIA_OFF_RESET_CAUSE 16'h022B
`define AIA_OFF_STARTUPS 16'h022C
`define AIA_OFF_MODEL 16'h022F

`define AIA_COIL_CLR_MAX 16'h00A2
`define AIA_COIL_CLR_MIN 16'h00C2
`define AIA_COIL_FACTORY 16'h00E2
`define AIA_COIL_REBOOT 16'h00E9
`define AIA_COIL_HIGH_MODE 16'h02BC
`define AIA_COIL_LOW_MODE 16'h02DC
`define AIA_COIL_CLR_HIGH 16'h02FC
`define AIA_COIL_CLR_LOW 16'h031C

`define AIA_RST_STATION 16'h0001
`define AIA_MAX_STATION 16'h00FF
`define AIA_RST_HIGH_THR 16'h7FFF
`define AIA_RST_LOW_THR 16'h8000
`define AIA_RST_RANGE 16'h0008
`define AIA_LINK_FAILED 16'hFFFF
`define AIA_LINK_NORMAL 16'h0000
`define AIA_CAUSE_POWER_ON 2'h1
`define AIA_CAUSE_WATCHDOG 2'h2
`define AIA_CAUSE_SOFTWARE 2'h3
`define AIA_STARTUP_MAX 15'h7FFF

`endif

/* hw/aia_pkg.sv */
// Types shared by the analog input register bank
package aia_pkg;

    typedef enum logic [1:0] {
        AIA_SP_COIL = 2'b00,
        AIA_SP_DISCRETE = 2'b01,
        AIA_SP_INPUT = 2'b10,
        AIA_SP_HOLDING = 2'b11
    } aia_space_t;

    typedef struct packed {
        logic valid;
        logic write;
        aia_space_t space;
        logic [15:0] addr;
        logic [15:0] wdata;
    } aia_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] rdata;
    } aia_resp_t;

    typedef struct packed {
        logic valid;
        logic [2:0] ch;
        logic [15:0] value;
    } aia_sample_t;

endpackage

/* hw/aia_chan.sv */
// One channel: input value, extremes and alarm flags
`timescale 1ns/100ps
module aia_chan (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sample_en,
    input wire logic [15:0] sample_value,
    input wire logic [15:0] high_thr,
    input wire logic [15:0] low_thr,
    input wire logic high_latch,
    input wire logic low_latch,
    input wire logic clr_high,
    input wire logic clr_low,
    input wire logic clr_max,
    input wire logic clr_min,
    output logic [15:0] value,
    output logic [15:0] hist_max,
    output logic [15:0] hist_min,
    output logic high_flag,
    output logic low_flag
);
    logic above;
    logic below;

    // [R1] Signed compare
    assign above = $signed(sample_value) > $signed(high_thr);
    // [R2] Signed compare
    assign below = $signed(sample_value) < $signed(low_thr);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            value <= 16'h0000;
        end else if (sample_en) begin
            value <= sample_value;
        end
    end

    // [R3] Maximum tracking
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hist_max <= 16'h8000;
        // [R16] Strictly greater, or any sample arriving with a clear
        end else if (sample_en &&
                     (clr_max || $signed(sample_value) > $signed(hist_max))) begin
            hist_max <= sample_value;
        end else if (clr_max) begin
            hist_max <= 16'h8000;
        end
    end

    // [R4] Minimum tracking
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hist_min <= 16'h7FFF;
        // [R16] Strictly less, or any sample arriving with a clear
        end else if (sample_en &&
                     (clr_min || $signed(sample_value) < $signed(hist_min))) begin
            hist_min <= sample_value;
        end else if (clr_min) begin
            hist_min <= 16'h7FFF;
        end
    end

    // [R13] Momentary or latching, new sample beats clear
    // [R15] Refresh on sample
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            high_flag <= 1'b0;
        end else if (sample_en) begin
            high_flag <= above | (high_latch & high_flag & ~clr_high);
        end else if (clr_high) begin
            high_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_flag <= 1'b0;
        end else if (sample_en) begin
            low_flag <= below | (low_latch & low_flag & ~clr_low);
        end else if (clr_low) begin
            low_flag <= 1'b0;
        end
    end
endmodule // aia_chan

/* test/aia_bank_sva.sv */
// Port checker for the analog input register bank
`timescale 1ns/100ps
`include "aia_consts.svh"
module aia_bank_sva #(
    parameter logic [15:0] MODEL_CODE = 16'h5A5A
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire aia_pkg::aia_req_t req,
    input wire aia_pkg::aia_sample_t sample,
    input wire logic link_ok_pin,
    input wire logic [1:0] cause_pin,
    input wire logic [14:0] boot_count_pin,
    input wire aia_pkg::aia_resp_t resp,
    input wire logic reboot_req,
    input wire logic factory_req,
    input wire logic [7:0] high_alarm_flags,
    input wire logic [7:0] low_alarm_flags
);
    import aia_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence rd_s(logic [1:0] sp, logic [15:0] a);
        req.valid && !req.write && req.space == sp && req.addr == a;
    endsequence
    sequence wr_s(logic [1:0] sp, logic [15:0] a);
        req.valid && req.write && req.space == sp && req.addr == a;
    endsequence
    chan_count_a: assert property (
        rd_s(2'h2, `AIA_OFF_CH_COUNT) |=> resp.ack && resp.rdata == 16'h0008)
        else $error("channel count read wrong");
    model_code_a: assert property (
        rd_s(2'h3, `AIA_OFF_MODEL) |=> resp.rdata == MODEL_CODE)
        else $error("model code read wrong");
    link_failed_a: assert property (
        (!link_ok_pin)[*4] ##0 rd_s(2'h2, `AIA_OFF_PEER_LINK)
        |=> resp.rdata[15]) else $error("failed link not negative");
    link_normal_a: assert property (
        link_ok_pin[*4] ##0 rd_s(2'h2, `AIA_OFF_PEER_LINK)
        |=> resp.rdata == 16'h0000) else $error("healthy link not zero");
    station_refuse_a: assert property (
        wr_s(2'h3, `AIA_OFF_STATION) ##0 req.wdata > 16'h00FF |=> resp.err)
        else $error("station above 255 accepted");
    max_readonly_a: assert property (
        wr_s(2'h2, `AIA_OFF_HISTORY_MAX) |=> resp.ack && resp.err)
        else $error("write to maximum accepted");
    thr_roundtrip_a: assert property (
        wr_s(2'h3, `AIA_OFF_HIGH_THR) ##1 !req.valid ##1
        rd_s(2'h3, `AIA_OFF_HIGH_THR) |=> resp.rdata == $past(req.wdata, 3))
        else $error("high threshold not kept");
    factory_pulse_a: assert property (
        wr_s(2'h0, `AIA_COIL_FACTORY) ##0 req.wdata[0] |=> factory_req)
        else $error("factory coil gave no pulse");
    reboot_pulse_a: assert property (
        wr_s(2'h0, `AIA_COIL_REBOOT) ##0 req.wdata[0] |=> reboot_req)
        else $error("reboot coil gave no pulse");
    idle_quiet_a: assert property (
        !req.valid |=> !factory_req && !reboot_req && !resp.ack)
        else $error("pulse without request");
endmodule // aia_bank_sva

bind aia_bank aia_bank_sva #(.MODEL_CODE(MODEL_CODE)) i_aia_bank_sva (
    .clk(clk), .sys_rst(sys_rst), .req(req), .sample(sample),
    .link_ok_pin(link_ok_pin), .cause_pin(cause_pin),
    .boot_count_pin(boot_count_pin), .resp(resp), .reboot_req(reboot_req),
    .factory_req(factory_req), .high_alarm_flags(high_alarm_flags),
    .low_alarm_flags(low_alarm_flags));

/* test/aia_host.sv */
// Host model issuing register requests
`timescale 1ns/100ps
module aia_host (
    input wire logic clk,
    output aia_pkg::aia_req_t req,
    input wire aia_pkg::aia_resp_t resp
);
    import aia_pkg::*;
    initial req = '0;
    // Released fields are scrambled so stale values cannot pass
    task automatic xfer(input logic wr, input logic [1:0] sp,
            input logic [15:0] a, input logic [15:0] d,
            output logic [15:0] rd, output logic er, output logic ok);
        int n;
        @(posedge clk);
        req <= '{1'b1, wr, aia_space_t'(sp), a, d};
        @(posedge clk);
        req <= '{1'b0, ~wr, aia_space_t'(~sp), ~a, ~d};
        #1;
        n = 0;
        while (resp.ack !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        rd = resp.rdata;
        er = resp.err;
        ok = resp.ack === 1'b1;
    endtask
endmodule // aia_host

/* test/aia_bank_tb.sv */
// Self-checking bench for the analog input register bank
`timescale 1ns/100ps
`include "aia_consts.svh"
module aia_bank_tb;
    import aia_pkg::*;
    // Arbitrary model code
    localparam logic [15:0] MODEL = 16'h3C3C;
    logic clk, sys_rst, link_ok_pin, reboot_req, factory_req, e, ok;
    logic [1:0] cause_pin;
    logic [14:0] boot_count_pin;
    logic [7:0] high_alarm_flags, low_alarm_flags;
    logic [15:0] v;
    aia_req_t req;
    aia_sample_t sample;
    aia_resp_t resp;
    int mismatches = 0, check_count = 0, cycles = 0;
    aia_bank #(.MODEL_CODE(MODEL)) i_aia_bank (.clk(clk), .sys_rst(sys_rst),
        .req(req), .sample(sample), .link_ok_pin(link_ok_pin),
        .cause_pin(cause_pin), .boot_count_pin(boot_count_pin), .resp(resp),
        .reboot_req(reboot_req), .factory_req(factory_req),
        .high_alarm_flags(high_alarm_flags), .low_alarm_flags(low_alarm_flags));
    aia_host i_aia_host (.clk(clk), .req(req), .resp(resp));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] x,
            input logic [15:0] g);
        check_count++;
        if (g !== x) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rd(input logic [1:0] sp, input logic [15:0] a,
            input string n, input logic [15:0] x);
        i_aia_host.xfer(1'b0, sp, a, 16'h0000, v, e, ok);
        chk(n, x, v);
        chk({n, " resp"}, 16'h0001, {14'h0, e, ok});
    endtask
    task automatic wr(input logic [1:0] sp, input logic [15:0] a,
            input logic [15:0] d, input logic xe);
        i_aia_host.xfer(1'b1, sp, a, d, v, e, ok);
        chk("write resp", {14'h0, xe, 1'b1}, {14'h0, e, ok});
    endtask
    task automatic smp(input logic [2:0] c, input logic [15:0] x);
        @(posedge clk);
        sample <= '{1'b1, c, x};
        @(posedge clk);
        sample <= '{1'b0, ~c, ~x};
    endtask
    task automatic do_reset(input logic [1:0] cc, input logic [14:0] bc);
        @(posedge clk);
        sys_rst <= 1'b1;
        cause_pin <= cc;
        boot_count_pin <= bc;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic t_defaults;
        for (int c = 0; c < 8; c++) begin
            rd(2'h3, `AIA_OFF_HIGH_THR + 16'(c), "high thr", 16'h7FFF);
            rd(2'h3, `AIA_OFF_LOW_THR + 16'(c), "low thr", 16'h8000);
        end
        rd(2'h3, `AIA_OFF_STATION, "station", 16'h0001);
        rd(2'h2, `AIA_OFF_CH_COUNT, "channels", 16'h0008);
        rd(2'h3, `AIA_OFF_MODEL, "model", MODEL);
        rd(2'h3, `AIA_OFF_RESET_CAUSE, "cause", 16'h0002);
        rd(2'h3, `AIA_OFF_STARTUPS, "boots", 16'h002A);
        wr(2'h3, `AIA_OFF_RESET_CAUSE, 16'h0001, 1'b1);
        i_aia_host.xfer(1'b0, 2'h3, 16'h0200, 16'h0000, v, e, ok);
        chk("unmapped", 16'h0003, {14'h0, e, ok});
        $display("defaults test done");
    endtask
    task automatic t_alarm;
        wr(2'h3, `AIA_OFF_HIGH_THR, 16'h0123, 1'b0);
        rd(2'h3, `AIA_OFF_HIGH_THR, "thr back", 16'h0123);
        wr(2'h3, `AIA_OFF_HIGH_THR + 16'h3, 16'h0064, 1'b0);
        wr(2'h3, `AIA_OFF_LOW_THR + 16'h3, 16'hFF9C, 1'b0);
        smp(3'h3, 16'h0065);
        rd(2'h1, `AIA_OFF_HIGH_FLAGS + 16'h3, "high flag", 16'h0001);
        chk("high port", 16'h0008, {8'h0, high_alarm_flags});
        smp(3'h3, 16'h0064);
        rd(2'h1, `AIA_OFF_HIGH_FLAGS + 16'h3, "high equal", 16'h0000);
        smp(3'h3, 16'hFF9B);
        rd(2'h1, `AIA_OFF_LOW_FLAGS + 16'h3, "low flag", 16'h0001);
        chk("low port", 16'h0008, {8'h0, low_alarm_flags});
        smp(3'h3, 16'hFF9C);
        rd(2'h1, `AIA_OFF_LOW_FLAGS + 16'h3, "low equal", 16'h0000);
        rd(2'h2, `AIA_OFF_INPUT_VALUE + 16'h3, "value", 16'hFF9C);
        $display("alarm test done");
    endtask
    task automatic t_latch;
        wr(2'h0, `AIA_COIL_HIGH_MODE + 16'h3, 16'h0001, 1'b0);
        wr(2'h0, `AIA_COIL_LOW_MODE + 16'h3, 16'h0001, 1'b0);
        smp(3'h3, 16'h0065);
        smp(3'h3, 16'hFF00);
        smp(3'h3, 16'h0000);
        rd(2'h1, `AIA_OFF_HIGH_FLAGS + 16'h3, "latched", 16'h0001);
        rd(2'h1, `AIA_OFF_LOW_FLAGS + 16'h3, "low latched", 16'h0001);
        wr(2'h0, `AIA_COIL_CLR_HIGH + 16'h3, 16'h0001, 1'b0);
        rd(2'h1, `AIA_OFF_HIGH_FLAGS + 16'h3, "cleared", 16'h0000);
        $display("latch test done");
    endtask
    task automatic t_extreme;
        logic [15:0] s[5] = '{16'h000A, 16'h001E, 16'h0014, 16'hFFFB, 16'h0};
        foreach (s[i]) smp(3'h5, s[i]);
        rd(2'h2, `AIA_OFF_HISTORY_MAX + 16'h5, "max", 16'h001E);
        rd(2'h2, `AIA_OFF_HISTORY_MIN + 16'h5, "min", 16'hFFFB);
        wr(2'h2, `AIA_OFF_HISTORY_MAX, 16'h0001, 1'b1);
        wr(2'h2, `AIA_OFF_HISTORY_MIN, 16'h0001, 1'b1);
        wr(2'h0, `AIA_COIL_CLR_MAX + 16'h5, 16'h0001, 1'b0);
        rd(2'h2, `AIA_OFF_HISTORY_MAX + 16'h5, "max clr", 16'h8000);
        rd(2'h2, `AIA_OFF_HISTORY_MIN + 16'h5, "min kept", 16'hFFFB);
        wr(2'h0, `AIA_COIL_CLR_MIN + 16'h5, 16'h0001, 1'b0);
        rd(2'h2, `AIA_OFF_HISTORY_MIN + 16'h5, "min clr", 16'h7FFF);
        $display("extremes test done");
    endtask
    task automatic t_station;
        wr(2'h3, `AIA_OFF_STATION, 16'h00FF, 1'b0);
        wr(2'h3, `AIA_OFF_STATION, 16'h0100, 1'b1);
        rd(2'h3, `AIA_OFF_STATION, "station", 16'h00FF);
        @(posedge clk);
        link_ok_pin <= 1'b0;
        repeat (4) @(posedge clk);
        rd(2'h2, `AIA_OFF_PEER_LINK, "link", `AIA_LINK_FAILED);
        @(posedge clk);
        link_ok_pin <= 1'b1;
        repeat (4) @(posedge clk);
        rd(2'h2, `AIA_OFF_PEER_LINK, "link", 16'h0000);
        $display("station and link test done");
    endtask
    task automatic t_boot;
        wr(2'h0, `AIA_COIL_FACTORY, 16'h0001, 1'b0);
        rd(2'h3, `AIA_OFF_STARTUPS, "boots", 16'h0000);
        rd(2'h3, `AIA_OFF_HIGH_THR, "thr restored", 16'h7FFF);
        rd(2'h3, `AIA_OFF_STATION, "station", 16'h0001);
        wr(2'h0, `AIA_COIL_REBOOT, 16'h0001, 1'b0);
        do_reset(2'h3, 15'h7FFF);
        rd(2'h3, `AIA_OFF_RESET_CAUSE, "cause", 16'h0003);
        rd(2'h3, `AIA_OFF_STARTUPS, "boots", 16'h7FFF);
        do_reset(2'h1, 15'h0004);
        rd(2'h3, `AIA_OFF_RESET_CAUSE, "cause", 16'h0001);
        rd(2'h3, `AIA_OFF_STARTUPS, "boots", 16'h0005);
        $display("boot test done");
    endtask
    initial begin
        sys_rst = 1'b1;
        link_ok_pin = 1'b1;
        cause_pin = 2'h2;
        boot_count_pin = 15'h0029;
        sample = '0;
        do_reset(2'h2, 15'h0029);
        t_defaults();
        t_alarm();
        t_latch();
        t_extreme();
        t_station();
        t_boot();
        stop_test();
    end
endmodule // aia_bank_tb
